// [bgd_pkg.sv]
package bgd_pkg;

    // Bargraph geometry: each segment spans one step of the full scale.
    localparam int SEG_COUNT = 20;
    localparam int PCT_FULL = 100;
    localparam int SEG_STEP_PCT = 5;
    localparam logic [4:0] LEVEL_SCALE = 5'(PCT_FULL / SEG_STEP_PCT);
    localparam logic [4:0] LEVEL_NONE = 5'h00;

    // Relays and the number of values converted to levels per sweep.
    localparam int NUM_RELAYS = 4;
    localparam int NUM_VALUES = 1 + 2 * NUM_RELAYS;
    localparam logic [3:0] IDX_MEAS = 4'h0;
    localparam logic [3:0] IDX_FIRST = 4'h1;
    localparam logic [3:0] IDX_SECOND = 4'h5;
    localparam logic [3:0] IDX_LAST = 4'(NUM_VALUES - 1);

    // Divider timing: quotient bits and cycles from start to done.
    localparam logic [2:0] DIV_TOP_BIT = 3'h4;
    localparam int DIV_LATENCY = 6;

    // Brightness levels and the dimming period in clock cycles.
    localparam logic [3:0] BRIGHT_MIN = 4'h1;
    localparam logic [3:0] BRIGHT_MAX = 4'h8;
    localparam logic [2:0] DIM_LAST = 3'h7;

    typedef enum logic [0:0] {BGD_LINE, BGD_POINT} bgd_style_t;

    typedef enum logic [2:0] {
        BGD_SC_OFF, BGD_SC_GREEN, BGD_SC_RED, BGD_SC_GREEN_ON_RED,
        BGD_SC_RED_ON_GREEN, BGD_SC_DARK_ON_GREEN, BGD_SC_DARK_ON_RED
    } bgd_scheme_t;

    typedef enum logic [1:0] {BGD_CL_DARK, BGD_CL_RED, BGD_CL_GREEN, BGD_CL_ORANGE} bgd_colour_t;

    typedef enum logic [1:0] {
        BGD_MK_NONE, BGD_MK_FIRST_ONLY, BGD_MK_SECOND_ONLY, BGD_MK_BOTH
    } bgd_marker_t;

    typedef enum logic [2:0] {
        BGD_AL_NO_SOURCE, BGD_AL_ABOVE, BGD_AL_BELOW, BGD_AL_CLOSED, BGD_AL_OPEN
    } bgd_alarm_t;

    // Per-relay configuration as handed over by the relay logic.
    typedef struct packed {
        bgd_marker_t marker_select;
        bgd_alarm_t alarm_condition;
        logic signed [15:0] first_threshold;
        logic signed [15:0] second_threshold;
    } bgd_relay_t;

    // Colours of the three bargraph roles for one scheme.
    typedef struct packed {
        bgd_colour_t meas;
        bgd_colour_t bg;
        bgd_colour_t mark;
    } bgd_palette_t;

endpackage : bgd_pkg

// [bgd_div.sv]
module bgd_div (
    input wire logic clk,
    input wire logic reset,
    input wire logic start,
    input wire logic [20:0] dividend,
    input wire logic [13:0] divisor,
    output logic done,
    output logic [4:0] quot
);

    logic [20:0] rem_r, rem_nxt;
    logic [4:0] quot_r, quot_nxt;
    logic [2:0] bit_r, bit_nxt;
    logic run_r, run_nxt;
    logic done_r, done_nxt;
    logic [13:0] den_r, den_nxt;
    logic [20:0] trial;

    ////////////////////////////////////////////////////////////////////////
    // Restoring division, one quotient bit per cycle, top bit first.
    always_comb begin
        rem_nxt = rem_r;
        quot_nxt = quot_r;
        bit_nxt = bit_r;
        run_nxt = run_r;
        den_nxt = den_r;
        done_nxt = 1'b0;
        trial = 21'(den_r) << bit_r;
        if (start) begin
            rem_nxt = dividend;
            den_nxt = divisor;
            quot_nxt = 5'h00;
            bit_nxt = bgd_pkg::DIV_TOP_BIT;
            run_nxt = 1'b1;
        end else if (run_r) begin
            if (rem_r >= trial) begin
                rem_nxt = rem_r - trial;
                quot_nxt[bit_r] = 1'b1;
            end
            if (bit_r == 3'h0) begin
                run_nxt = 1'b0;
                done_nxt = 1'b1;
            end else begin
                bit_nxt = bit_r - 3'h1;
            end
        end
    end

    // Registers only; a quotient of at most twenty fits the five bits.
    always_ff @(posedge clk) begin
        if (reset) begin
            rem_r <= 21'h000000;
            quot_r <= 5'h00;
            bit_r <= 3'h0;
            run_r <= 1'b0;
            done_r <= 1'b0;
            den_r <= 14'h0000;
        end else begin
            rem_r <= rem_nxt;
            quot_r <= quot_nxt;
            bit_r <= bit_nxt;
            run_r <= run_nxt;
            done_r <= done_nxt;
            den_r <= den_nxt;
        end
    end

    assign done = done_r;
    assign quot = quot_r;

    div_latency_a: assert property (@(posedge clk) disable iff (reset)
        start |-> ##6 done)
        else $error("Divider did not finish in six cycles.");

endmodule : bgd_div

// [bgd_bar.sv]
module bgd_bar (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic signed [15:0] DISPLAY_VALUE,
    input wire logic signed [15:0] SCALE_LOW_POINT,
    input wire logic signed [15:0] SCALE_HIGH_POINT,
    input wire bgd_pkg::bgd_style_t BAR_STYLE,
    input wire bgd_pkg::bgd_scheme_t COLOUR_SCHEME,
    input wire bgd_pkg::bgd_relay_t RELAY_CFG [bgd_pkg::NUM_RELAYS],
    input wire logic [3:0] RELAY_CLOSED,
    input wire logic [3:0] BRIGHTNESS,
    output logic [19:0] SEG_RED,
    output logic [19:0] SEG_GREEN,
    output logic BAR_ALARM,
    output logic BRIGHT_ON
);

    typedef enum {BGD_S_LOAD, BGD_S_DIV} bgd_state_t;

    // Segment index that stands for a level; level zero shares the first segment.
    function automatic logic [4:0] seg_of(input logic [4:0] lvl);
        seg_of = (lvl == bgd_pkg::LEVEL_NONE) ? 5'h00 : lvl - 5'h01;
    endfunction : seg_of

    // Red and green drive of one colour; orange is both.
    function automatic logic [1:0] rg_of(input bgd_pkg::bgd_colour_t c);
        rg_of = {c == bgd_pkg::BGD_CL_RED || c == bgd_pkg::BGD_CL_ORANGE,
                 c == bgd_pkg::BGD_CL_GREEN || c == bgd_pkg::BGD_CL_ORANGE};
    endfunction : rg_of

    function automatic bgd_pkg::bgd_palette_t palette(input bgd_pkg::bgd_scheme_t s);
        case (s)
            bgd_pkg::BGD_SC_GREEN: palette = {bgd_pkg::BGD_CL_GREEN, bgd_pkg::BGD_CL_DARK,
                                              bgd_pkg::BGD_CL_RED};
            bgd_pkg::BGD_SC_RED: palette = {bgd_pkg::BGD_CL_RED, bgd_pkg::BGD_CL_DARK,
                                            bgd_pkg::BGD_CL_GREEN};
            bgd_pkg::BGD_SC_GREEN_ON_RED: palette = {bgd_pkg::BGD_CL_GREEN,
                                                     bgd_pkg::BGD_CL_RED,
                                                     bgd_pkg::BGD_CL_ORANGE};
            bgd_pkg::BGD_SC_RED_ON_GREEN: palette = {bgd_pkg::BGD_CL_RED,
                                                     bgd_pkg::BGD_CL_GREEN,
                                                     bgd_pkg::BGD_CL_ORANGE};
            bgd_pkg::BGD_SC_DARK_ON_GREEN: palette = {bgd_pkg::BGD_CL_DARK,
                                                      bgd_pkg::BGD_CL_GREEN,
                                                      bgd_pkg::BGD_CL_RED};
            bgd_pkg::BGD_SC_DARK_ON_RED: palette = {bgd_pkg::BGD_CL_DARK,
                                                    bgd_pkg::BGD_CL_RED,
                                                    bgd_pkg::BGD_CL_GREEN};
            default: palette = {bgd_pkg::BGD_CL_DARK, bgd_pkg::BGD_CL_DARK,
                                bgd_pkg::BGD_CL_DARK};
        endcase
    endfunction : palette

    bgd_state_t state_r, state_nxt;
    logic [3:0] idx_r, idx_nxt;
    logic [4:0] level_r [bgd_pkg::NUM_VALUES];
    logic [4:0] level_nxt [bgd_pkg::NUM_VALUES];
    logic signed [15:0] val_sel;
    logic signed [16:0] num, den;
    logic div_start;
    logic [20:0] div_dividend;
    logic div_done;
    logic [4:0] div_quot;

    ////////////////////////////////////////////////////////////////////////
    // Level sweep: the measurement and all eight thresholds are converted in
    // turn through one shared divider, trading latency (about sixty cycles
    // per sweep) for a single division circuit.
    always_comb begin
        if (idx_r == bgd_pkg::IDX_MEAS) begin
            val_sel = DISPLAY_VALUE;
        end else if (idx_r < bgd_pkg::IDX_SECOND) begin
            val_sel = RELAY_CFG[2'(idx_r - bgd_pkg::IDX_FIRST)].first_threshold;
        end else begin
            val_sel = RELAY_CFG[2'(idx_r - bgd_pkg::IDX_SECOND)].second_threshold;
        end
        num = 17'(val_sel) - 17'(SCALE_LOW_POINT);
        den = 17'(SCALE_HIGH_POINT) - 17'(SCALE_LOW_POINT);
        if (den < 0) begin
            num = -num;
            den = -den;
        end
        // Rounded to the nearest step: (20 * num + den / 2) / den.
        div_dividend = 21'(num) * 21'(bgd_pkg::LEVEL_SCALE) + 21'(den >>> 1);
        state_nxt = state_r;
        idx_nxt = idx_r;
        level_nxt = level_r;
        div_start = 1'b0;
        case (state_r)
            BGD_S_LOAD: begin
                if (num <= 0) begin
                    level_nxt[idx_r] = bgd_pkg::LEVEL_NONE;
                end else if (num >= den) begin
                    level_nxt[idx_r] = bgd_pkg::LEVEL_SCALE;
                end else begin
                    div_start = 1'b1;
                    state_nxt = BGD_S_DIV;
                end
                if (state_nxt == BGD_S_LOAD) begin
                    idx_nxt = (idx_r == bgd_pkg::IDX_LAST) ? bgd_pkg::IDX_MEAS : idx_r + 4'h1;
                end
            end
            BGD_S_DIV: begin
                if (div_done) begin
                    level_nxt[idx_r] = div_quot;
                    state_nxt = BGD_S_LOAD;
                    idx_nxt = (idx_r == bgd_pkg::IDX_LAST) ? bgd_pkg::IDX_MEAS : idx_r + 4'h1;
                end
            end
            default: state_nxt = BGD_S_LOAD;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            state_r <= BGD_S_LOAD;
            idx_r <= bgd_pkg::IDX_MEAS;
            for (int k = 0; k < bgd_pkg::NUM_VALUES; k++) begin
                level_r[k] <= bgd_pkg::LEVEL_NONE;
            end
        end else begin
            state_r <= state_nxt;
            idx_r <= idx_nxt;
            level_r <= level_nxt;
        end
    end

    bgd_div u_div (
        .clk(CLK),
        .reset(RESET),
        .start(div_start),
        .dividend(div_dividend),
        .divisor(den[13:0]),
        .done(div_done),
        .quot(div_quot)
    );

    ////////////////////////////////////////////////////////////////////////
    // Alarm combination from the current inputs, one term per relay.
    logic [3:0] relay_alarm;
    logic alarm_any;
    always_comb begin
        for (int r = 0; r < bgd_pkg::NUM_RELAYS; r++) begin
            case (RELAY_CFG[r].alarm_condition)
                bgd_pkg::BGD_AL_ABOVE:
                    relay_alarm[r] = DISPLAY_VALUE > RELAY_CFG[r].first_threshold;
                bgd_pkg::BGD_AL_BELOW:
                    relay_alarm[r] = DISPLAY_VALUE < RELAY_CFG[r].first_threshold;
                bgd_pkg::BGD_AL_CLOSED: relay_alarm[r] = RELAY_CLOSED[r];
                bgd_pkg::BGD_AL_OPEN: relay_alarm[r] = !RELAY_CLOSED[r];
                default: relay_alarm[r] = 1'b0;
            endcase
        end
        alarm_any = |relay_alarm;
    end

    ////////////////////////////////////////////////////////////////////////
    // Dimming: the segments are lit for BRIGHTNESS of every eight cycles;
    // values outside one..eight are held to the nearest end.
    logic [2:0] dim_r, dim_nxt;
    logic [3:0] bright_lvl;
    logic bright_nxt;
    always_comb begin
        bright_lvl = BRIGHTNESS;
        if (bright_lvl < bgd_pkg::BRIGHT_MIN) bright_lvl = bgd_pkg::BRIGHT_MIN;
        if (bright_lvl > bgd_pkg::BRIGHT_MAX) bright_lvl = bgd_pkg::BRIGHT_MAX;
        dim_nxt = (dim_r == bgd_pkg::DIM_LAST) ? 3'h0 : dim_r + 3'h1;
        bright_nxt = 4'(dim_r) < bright_lvl;
    end

    ////////////////////////////////////////////////////////////////////////
    // Segment colours: a marker wins over the measurement, which wins over
    // the background.
    bgd_pkg::bgd_palette_t pal;
    logic [19:0] red_nxt, green_nxt;
    logic lit, mark;
    logic [1:0] rg;
    always_comb begin
        pal = palette(COLOUR_SCHEME);
        red_nxt = 20'h00000;
        green_nxt = 20'h00000;
        for (int i = 0; i < bgd_pkg::SEG_COUNT; i++) begin
            lit = (BAR_STYLE == bgd_pkg::BGD_LINE) ? (5'(i) < level_r[0])
                                                   : (5'(i) == seg_of(level_r[0]));
            mark = 1'b0;
            for (int r = 0; r < bgd_pkg::NUM_RELAYS; r++) begin
                if ((RELAY_CFG[r].marker_select == bgd_pkg::BGD_MK_FIRST_ONLY ||
                     RELAY_CFG[r].marker_select == bgd_pkg::BGD_MK_BOTH) &&
                    5'(i) == seg_of(level_r[bgd_pkg::IDX_FIRST + r])) mark = 1'b1;
                if ((RELAY_CFG[r].marker_select == bgd_pkg::BGD_MK_SECOND_ONLY ||
                     RELAY_CFG[r].marker_select == bgd_pkg::BGD_MK_BOTH) &&
                    5'(i) == seg_of(level_r[bgd_pkg::IDX_SECOND + r])) mark = 1'b1;
            end
            rg = rg_of(mark ? pal.mark : (lit ? pal.meas : pal.bg));
            if (alarm_any) rg = {rg[0], rg[1]};
            red_nxt[i] = rg[1] & bright_nxt;
            green_nxt[i] = rg[0] & bright_nxt;
        end
    end

    // All outputs come straight from these flip-flops.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            dim_r <= 3'h0;
            SEG_RED <= 20'h00000;
            SEG_GREEN <= 20'h00000;
            BAR_ALARM <= 1'b0;
            BRIGHT_ON <= 1'b0;
        end else begin
            dim_r <= dim_nxt;
            SEG_RED <= red_nxt;
            SEG_GREEN <= green_nxt;
            BAR_ALARM <= alarm_any;
            BRIGHT_ON <= bright_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks of the segment, alarm and dimming behaviour.
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    logic plain_green, no_marks;
    assign no_marks = RELAY_CFG[0].marker_select == bgd_pkg::BGD_MK_NONE &&
                      RELAY_CFG[1].marker_select == bgd_pkg::BGD_MK_NONE &&
                      RELAY_CFG[2].marker_select == bgd_pkg::BGD_MK_NONE &&
                      RELAY_CFG[3].marker_select == bgd_pkg::BGD_MK_NONE;
    assign plain_green = COLOUR_SCHEME == bgd_pkg::BGD_SC_GREEN && no_marks && bright_nxt;

    alarm_or_a: assert property (BAR_ALARM == $past(|relay_alarm))
        else $error("Bar alarm does not follow the relay alarm OR.");
    relay_above_a: assert property (
        RELAY_CFG[2].alarm_condition == bgd_pkg::BGD_AL_ABOVE &&
        DISPLAY_VALUE > RELAY_CFG[2].first_threshold |=> BAR_ALARM)
        else $error("Value above first threshold raised no alarm.");
    off_dark_a: assert property (
        COLOUR_SCHEME == bgd_pkg::BGD_SC_OFF |=> SEG_RED == 20'h00000 && SEG_GREEN == 20'h00000)
        else $error("Bar lit while switched off.");
    line_fill_a: assert property (
        plain_green && !alarm_any && BAR_STYLE == bgd_pkg::BGD_LINE
        |=> SEG_GREEN == 20'((21'h000001 << $past(level_r[0])) - 21'h000001))
        else $error("Line fill does not match the level.");
    point_one_a: assert property (
        plain_green && !alarm_any && BAR_STYLE == bgd_pkg::BGD_POINT |=> $onehot(SEG_GREEN))
        else $error("Point style did not light exactly one segment.");
    alarm_swap_a: assert property (
        plain_green && alarm_any |=> SEG_GREEN == 20'h00000 && SEG_RED != 20'h00000
                                     || $past(level_r[0]) == bgd_pkg::LEVEL_NONE)
        else $error("Alarm did not swap green to red.");
    level_clamp_a: assert property (level_r[0] <= bgd_pkg::LEVEL_SCALE)
        else $error("Level exceeds full scale.");
    dim_min_a: assert property (
        BRIGHT_ON && $past(BRIGHTNESS) == bgd_pkg::BRIGHT_MIN |-> $past(dim_r) == 3'h0)
        else $error("Lowest brightness lit above_threshold than one cycle in eight.");
    marker_show_a: assert property (
        COLOUR_SCHEME == bgd_pkg::BGD_SC_GREEN && bright_nxt && !alarm_any &&
        RELAY_CFG[0].marker_select == bgd_pkg::BGD_MK_BOTH |=> SEG_RED != 20'h00000)
        else $error("Selected markers not shown.");

    cov_line_c: cover property (plain_green && BAR_STYLE == bgd_pkg::BGD_LINE);
    cov_point_c: cover property (plain_green && BAR_STYLE == bgd_pkg::BGD_POINT);
    cov_alarm_c: cover property (!BAR_ALARM ##1 BAR_ALARM);
    cov_full_c: cover property (level_r[0] == bgd_pkg::LEVEL_SCALE);

endmodule : bgd_bar

// [bgd_led_model.sv]
module bgd_led_model (
    input wire logic clk,
    input wire logic clr,
    input wire logic [19:0] seg_red,
    input wire logic [19:0] seg_green,
    input wire logic bright_on,
    output logic [39:0] seen,
    output logic [3:0] on_cnt
);
    timeunit 1ns;
    timeprecision 1ps;

    // The eye only sees the segments in the lit dimming phase.
    // The dark phase holds the last picture, so the result does not depend on
    // where in the dimming period the bench samples.
    always_ff @(posedge clk) begin
        if (bright_on) begin
            seen <= {seg_red, seg_green};
        end
        on_cnt <= clr ? 4'h0 : on_cnt + 4'(bright_on);
    end

endmodule : bgd_led_model

// [bgd_bar_tb.sv]
module bgd_bar_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // Palettes {meas, bg, mark}; the colour codes are 0 dark, 1 red, 2 green and 3 orange.
    localparam logic [5:0] PAL [8] = '{6'h00, 6'h21, 6'h12, 6'h27, 6'h1B, 6'h09, 6'h06, 6'h00};

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic clr = 1'b1;
    logic signed [15:0] w = 16'sh0000;
    logic signed [15:0] lo = 16'sh0000;
    logic signed [15:0] hi = 16'sh03E8;
    bgd_pkg::bgd_style_t style = bgd_pkg::BGD_LINE;
    bgd_pkg::bgd_scheme_t scheme = bgd_pkg::BGD_SC_GREEN;
    bgd_pkg::bgd_relay_t cfg [bgd_pkg::NUM_RELAYS];
    logic [3:0] closed = 4'h0;
    logic [3:0] bright = 4'h8;
    logic [19:0] seg_red;
    logic [19:0] seg_green;
    logic bar_alarm;
    logic bright_on;
    logic [39:0] seen;
    logic [3:0] on_cnt;
    int n_mismatch = 0;
    int comparisons = 0;

    // Free-running clock at 100 MHz.
    always #5 clk = ~clk;

    bgd_bar u_bgd_bar (.CLK(clk), .RESET(reset), .DISPLAY_VALUE(w), .SCALE_LOW_POINT(lo),
        .SCALE_HIGH_POINT(hi), .BAR_STYLE(style), .COLOUR_SCHEME(scheme), .RELAY_CFG(cfg),
        .RELAY_CLOSED(closed), .BRIGHTNESS(bright), .SEG_RED(seg_red),
        .SEG_GREEN(seg_green), .BAR_ALARM(bar_alarm), .BRIGHT_ON(bright_on));

    bgd_led_model u_bgd_led_model (.clk(clk), .clr(clr), .seg_red(seg_red),
        .seg_green(seg_green), .bright_on(bright_on), .seen(seen), .on_cnt(on_cnt));

    ////////////////////////////////////////////////////////////////////////////////
    // Reference model: level, segment colours and alarm from the current inputs.
    function automatic int lvl(int v);
        int num;
        int den;
        num = (v - lo) * 20;
        den = hi - lo;
        if (den == 0) return (v > lo) ? 20 : 0;
        if (den < 0) begin
            num = -num;
            den = -den;
        end
        if (num <= 0) return 0;
        if (num >= 20 * den) return 20;
        return (2 * num + den) / (2 * den);
    endfunction : lvl

    function automatic logic exp_alarm();
        logic a;
        a = 1'b0;
        for (int r = 0; r < 4; r++) begin
            case (cfg[r].alarm_condition)
                bgd_pkg::BGD_AL_ABOVE: a = a | (w > cfg[r].first_threshold);
                bgd_pkg::BGD_AL_BELOW: a = a | (w < cfg[r].first_threshold);
                bgd_pkg::BGD_AL_CLOSED: a = a | closed[r];
                bgd_pkg::BGD_AL_OPEN: a = a | !closed[r];
                default: a = a;
            endcase
        end
        return a;
    endfunction : exp_alarm

    function automatic logic [39:0] exp_bar(int n, logic al);
        bgd_pkg::bgd_palette_t p;
        logic [19:0] mk;
        logic [19:0] r;
        logic [19:0] g;
        logic [1:0] c;
        logic [1:0] ms;
        logic lit;
        int m;
        p = bgd_pkg::bgd_palette_t'(PAL[scheme]);
        mk = 20'h00000;
        for (int k = 0; k < 4; k++) begin
            ms = cfg[k].marker_select;
            m = lvl(cfg[k].first_threshold);
            if (ms[0]) mk[(m == 0) ? 0 : m - 1] = 1'b1;
            m = lvl(cfg[k].second_threshold);
            if (ms[1]) mk[(m == 0) ? 0 : m - 1] = 1'b1;
        end
        for (int i = 0; i < 20; i++) begin
            lit = (style == bgd_pkg::BGD_LINE) ? (i < n) : (i == ((n == 0) ? 0 : n - 1));
            c = mk[i] ? p.mark : (lit ? p.meas : p.bg);
            if (al && (c == 2'h1 || c == 2'h2)) c = ~c;
            r[i] = c[0];
            g[i] = c[1];
        end
        return {r, g};
    endfunction : exp_bar

    ////////////////////////////////////////////////////////////////////////////////
    // Compare tasks, scenario tasks and the single place where the run ends.
    task automatic cmp_seg(logic [39:0] got, logic [39:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_seg

    task automatic cmp_flag(logic [3:0] got, logic [3:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_flag

    // Worst-case refresh is a full sweep of about 63 cycles, so 100 always settles.
    task automatic run(bgd_pkg::bgd_style_t s, bgd_pkg::bgd_scheme_t c, int v);
        style = s;
        scheme = c;
        w = 16'(v);
        repeat (100) @(negedge clk);
        cmp_seg(seen, exp_bar(lvl(w), exp_alarm()));
        cmp_flag({3'h0, bar_alarm}, {3'h0, exp_alarm()});
        $display("test done: style %0d scheme %0d value %0d", s, c, v);
    endtask : run

    task automatic dim(logic [3:0] b, logic [3:0] exp);
        bright = b;
        repeat (4) @(negedge clk);
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        repeat (8) @(negedge clk);
        cmp_flag(on_cnt, exp);
        $display("test done: brightness %0d", b);
    endtask : dim

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence; every input changes on the falling edge only.
    initial begin
        for (int r = 0; r < 4; r++) cfg[r] = '0;
        repeat (8) @(negedge clk);
        reset = 1'b0;
        run(bgd_pkg::BGD_LINE, bgd_pkg::BGD_SC_GREEN, 500);
        run(bgd_pkg::BGD_LINE, bgd_pkg::BGD_SC_GREEN, 526);
        run(bgd_pkg::BGD_POINT, bgd_pkg::BGD_SC_GREEN, 500);
        run(bgd_pkg::BGD_POINT, bgd_pkg::BGD_SC_GREEN, -100);
        run(bgd_pkg::BGD_LINE, bgd_pkg::BGD_SC_GREEN, 2000);
        run(bgd_pkg::BGD_LINE, bgd_pkg::BGD_SC_GREEN, -100);
        lo = 16'sh03E8;
        hi = 16'sh0000;
        run(bgd_pkg::BGD_LINE, bgd_pkg::BGD_SC_GREEN, 250);
        lo = 16'sh0000;
        hi = 16'sh03E8;
        for (int s = 0; s < 7; s++) run(bgd_pkg::BGD_LINE, bgd_pkg::bgd_scheme_t'(s), 500);
        cfg[0].first_threshold = 16'sh00C8;
        cfg[0].second_threshold = 16'sh0320;
        // Markers sit on both sides of the fill so override of fill and background shows.
        for (int m = 0; m < 4; m++) begin
            cfg[0].marker_select = bgd_pkg::bgd_marker_t'(m);
            run(bgd_pkg::BGD_LINE, bgd_pkg::BGD_SC_GREEN_ON_RED, 500);
        end
        // Both markers in red over a green fill, with no alarm pending.
        run(bgd_pkg::BGD_LINE, bgd_pkg::BGD_SC_GREEN, 500);
        cfg[2].first_threshold = 16'sh012C;
        for (int a = 0; a < 10; a++) begin
            cfg[2].alarm_condition = bgd_pkg::bgd_alarm_t'(a / 2);
            closed = {1'b1, a[0], 2'h0};
            run(bgd_pkg::BGD_LINE, bgd_pkg::BGD_SC_RED_ON_GREEN, 500);
        end
        // Markers off so the swap of a plain green point to red stands alone.
        cfg[0].marker_select = bgd_pkg::BGD_MK_NONE;
        cfg[2].alarm_condition = bgd_pkg::BGD_AL_BELOW;
        cfg[3].alarm_condition = bgd_pkg::BGD_AL_OPEN;
        closed = 4'h0;
        run(bgd_pkg::BGD_POINT, bgd_pkg::BGD_SC_GREEN, 500);
        dim(4'h0, 4'h1);
        dim(4'h1, 4'h1);
        dim(4'h3, 4'h3);
        dim(4'h8, 4'h8);
        dim(4'h9, 4'h8);
        test_done();
    end

    // Watchdog sized well above the roughly 3100 cycles the sequence needs.
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        test_done();
    end

endmodule : bgd_bar_tb
